//--- common/scl_pkg.sv
package scl_pkg;

  // Times in their own units, cycle counts derived at 100 MHz
  localparam int CLK_PERIOD_NS       = 10;
  localparam int POR_DELAY_US        = 4000;
  localparam int POR_DELAY_CYC       = POR_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int INIT_MIN_US         = 175;
  localparam int INIT_MAX_US         = 437;
  localparam int INIT_OSC_CYC        = INIT_MIN_US * 1000 / CLK_PERIOD_NS;
  localparam int USR_ENABLE_PERIODS  = 4;
  localparam int USR_INIT_PERIODS    = 8576;
  localparam int STROBE_MIN_NS       = 250;
  localparam int STROBE_MIN_CYC      = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXTRA_FALL_EDGES    = 2;
  localparam int OSC_MIN_KHZ         = 5300;
  localparam int OSC_MAX_KHZ         = 12500;
  // Default bitstream length: smallest documented size
  localparam longint BITSTREAM_BITS  = 64'd137598880;
  localparam int CNT_W               = 32;
  localparam int CONFIG_CLOCK_MAX_CYC        = 8;

  typedef enum logic [2:0] {
    SCL_POR,
    SCL_CLEAR,
    SCL_LOAD,
    SCL_WAIT_EDGES,
    SCL_INIT,
    SCL_USER
  } scl_state_t;

  typedef struct packed {
    logic cfgStatusOut;
    logic cfgStatusOe;
    logic cfgComplete;
    logic initDoneOut;
    logic initDoneOe;
  } scl_pins_t;

endpackage : scl_pkg

//--- hw/scl_config_loader.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Request low leaves user mode, restarts configuration
// - Status held low through power-on delay
// - Status released high when ready
// - Complete low during power-up and loading
// - Complete rises after all bits received
// - Serial pin released as user pin
// - Init-done low until initialization ends
// - Oscillator init takes 175 to 437 us
// - User clock enabled after four clock periods
// - User-clock init lasts 8576 user periods
// - Watchdog tolerates 5.3 to 12.5 MHz
module scl_config_loader #(
  parameter int     POR_CYC       = scl_pkg::POR_DELAY_CYC,
  parameter int     INIT_CYC      = scl_pkg::INIT_OSC_CYC,
  parameter int     USR_PERIODS   = scl_pkg::USR_INIT_PERIODS,
  parameter longint BITS          = scl_pkg::BITSTREAM_BITS,
  parameter int     WDOG_TICKS    = 65536
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         reconfig_request_n,
  input  wire logic         config_clock,
  input  wire logic         config_serial_in,
  input  wire logic         user_init_clock,
  input  wire logic         initDoneEnable,
  input  wire logic         userClockInitSel,
  input  wire logic         oscTick,
  input  wire logic         reconfigStrobe,
  input  wire logic         watchdogRestart,
  input  wire logic         watchdogEnable,
  input  wire logic         userPinOut,
  input  wire logic         userPinOe,
  output scl_pkg::scl_pins_t pins,
  output logic              serialPinOut,
  output logic              serialPinOe,
  output logic              serialPinUserIn,
  output logic              bitValid,
  output logic              bitData,
  output logic              userMode,
  output logic              watchdogExpired
);
  scl_pkg::scl_state_t state;
  scl_pkg::scl_state_t next_state;

  logic [scl_pkg::CNT_W-1:0] cnt;
  logic [scl_pkg::CNT_W-1:0] next_cnt;
  logic [scl_pkg::CNT_W-1:0] bitCnt;
  logic [1:0]                edgeCnt;
  logic [scl_pkg::CNT_W-1:0] wdog;
  logic                      optLoaded;

  logic dclkRise;
  logic dclkFall;
  logic usrRise;
  logic usrUnused;
  logic dclkUnused;
  logic reconfigOk;
  logic restartOk;

  scl_edge_detect uDclk (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sig     (config_clock),
    .rise    (dclkRise),
    .fall    (dclkFall)
  );

  scl_edge_detect uUsr (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sig     (user_init_clock),
    .rise    (usrRise),
    .fall    (usrUnused)
  );

  scl_pulse_stretch_check #(.MIN_CYC(scl_pkg::STROBE_MIN_CYC)) uReconf (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .strobe   (reconfigStrobe),
    .accepted (reconfigOk)
  );

  scl_pulse_stretch_check #(.MIN_CYC(scl_pkg::STROBE_MIN_CYC)) uRestart (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .strobe   (watchdogRestart),
    .accepted (restartOk)
  );

  assign dclkUnused = dclkRise & dclkFall;

  wire restartReq  = !reconfig_request_n || reconfigOk || watchdogExpired;
  wire lastBit     = (bitCnt == scl_pkg::CNT_W'(BITS - 1));
  wire edgesDone   = (edgeCnt == 2'(scl_pkg::EXTRA_FALL_EDGES - 1));
  wire porDone     = (cnt == scl_pkg::CNT_W'(POR_CYC - 1));
  // User clock counted only after the enable delay of four clock periods
  wire [scl_pkg::CNT_W-1:0] usrEnDelay =
    scl_pkg::CNT_W'(scl_pkg::USR_ENABLE_PERIODS * scl_pkg::CONFIG_CLOCK_MAX_CYC);
  wire usrInitDone = (cnt == usrEnDelay + scl_pkg::CNT_W'(USR_PERIODS));
  wire oscInitDone = (cnt == scl_pkg::CNT_W'(INIT_CYC - 1));

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      scl_pkg::SCL_POR: begin
        next_cnt = cnt + 1'b1;
        if (porDone) begin
          next_state = scl_pkg::SCL_CLEAR;
          next_cnt   = '0;
        end
      end
      scl_pkg::SCL_CLEAR: begin
        if (reconfig_request_n) next_state = scl_pkg::SCL_LOAD;
      end
      scl_pkg::SCL_LOAD: begin
        if (dclkRise && lastBit) next_state = scl_pkg::SCL_WAIT_EDGES;
      end
      scl_pkg::SCL_WAIT_EDGES: begin
        if (dclkFall && edgesDone) begin
          next_state = scl_pkg::SCL_INIT;
          next_cnt   = '0;
        end
      end
      scl_pkg::SCL_INIT: begin
        if (userClockInitSel) begin
          if (cnt < usrEnDelay) next_cnt = cnt + 1'b1;
          else if (usrRise)     next_cnt = cnt + 1'b1;
          if (usrInitDone) next_state = scl_pkg::SCL_USER;
        end else begin
          next_cnt = cnt + 1'b1;
          if (oscInitDone) next_state = scl_pkg::SCL_USER;
        end
      end
      scl_pkg::SCL_USER: next_state = scl_pkg::SCL_USER;
      default: next_state = scl_pkg::SCL_POR;
    endcase
    if (restartReq && state != scl_pkg::SCL_POR) begin
      next_state = scl_pkg::SCL_CLEAR;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= scl_pkg::SCL_POR;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Bit counter and sampled data on rising clock edges
  always_ff @(posedge sys_clk) begin
    if (!rstn || state != scl_pkg::SCL_LOAD) begin
      bitCnt   <= '0;
      bitValid <= 1'b0;
      bitData  <= 1'b0;
    end else begin
      bitValid <= dclkRise;
      if (dclkRise) begin
        bitData <= config_serial_in;
        bitCnt  <= bitCnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || state != scl_pkg::SCL_WAIT_EDGES) edgeCnt <= 2'h0;
    else if (dclkFall)                             edgeCnt <= edgeCnt + 2'h1;
  end

  // Option bit counts as loaded once loading has finished
  always_ff @(posedge sys_clk) begin
    if (!rstn || state == scl_pkg::SCL_CLEAR) optLoaded <= 1'b0;
    else if (state == scl_pkg::SCL_WAIT_EDGES) optLoaded <= initDoneEnable;
  end

  // Watchdog counts oscillator ticks; limit sized for the fastest oscillator
  always_ff @(posedge sys_clk) begin
    if (!rstn || state != scl_pkg::SCL_USER || !watchdogEnable || restartOk)
      wdog <= '0;
    else if (oscTick)
      wdog <= wdog + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) watchdogExpired <= 1'b0;
    else       watchdogExpired <= (wdog == scl_pkg::CNT_W'(WDOG_TICKS)) && !watchdogExpired;
  end

  // Open-drain: enable high pulls low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pins     <= '{cfgStatusOut: 1'b0, cfgStatusOe: 1'b1, cfgComplete: 1'b0,
                    initDoneOut: 1'b0, initDoneOe: 1'b0};
      userMode <= 1'b0;
    end else begin
      pins.cfgStatusOut <= 1'b0;
      pins.cfgStatusOe  <= (next_state == scl_pkg::SCL_POR) ||
                           (next_state == scl_pkg::SCL_CLEAR);
      pins.cfgComplete  <= (next_state == scl_pkg::SCL_WAIT_EDGES) ||
                           (next_state == scl_pkg::SCL_INIT) ||
                           (next_state == scl_pkg::SCL_USER);
      pins.initDoneOut  <= 1'b0;
      pins.initDoneOe   <= optLoaded && (next_state != scl_pkg::SCL_USER)
                           && (next_state != scl_pkg::SCL_CLEAR);
      userMode          <= (next_state == scl_pkg::SCL_USER);
    end
  end

  // Serial pin becomes a user pin in user mode
  assign serialPinOut    = userMode ? userPinOut : 1'b0;
  assign serialPinOe     = userMode ? userPinOe : 1'b0;
  assign serialPinUserIn = userMode ? config_serial_in : 1'b0;
  // clock left steady by host; no edges expected after init
endmodule : scl_config_loader
`default_nettype wire

//--- hw/scl_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module scl_edge_detect (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  logic prev;

  always_ff @(posedge sys_clk) begin
    if (!rstn) prev <= 1'b0;
    else       prev <= sig;
  end

  assign rise = sig & ~prev;
  assign fall = ~sig & prev;
endmodule : scl_edge_detect
`default_nettype wire

//--- hw/scl_pulse_stretch_check.sv
`timescale 1ns/1ns
`default_nettype none
// Accepts a strobe only after it has stood high for the minimum width
module scl_pulse_stretch_check #(
  parameter int MIN_CYC = 25
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic strobe,
  output logic      accepted
);
  logic [15:0] run;
  wire         reached = (run == 16'(MIN_CYC - 1));
  wire         spent   = (run == 16'(MIN_CYC));

  // Count parks at the width, one past the trigger value, so a held strobe never pulses twice
  always_ff @(posedge sys_clk) begin
    if (!rstn)          run <= 16'h0000;
    else if (!strobe)   run <= 16'h0000;
    else if (!spent)    run <= run + 16'h0001;
  end

  // One pulse when the width is first met; short glitches are ignored
  always_ff @(posedge sys_clk) begin
    if (!rstn) accepted <= 1'b0;
    else       accepted <= strobe && reached;
  end
endmodule : scl_pulse_stretch_check
`default_nettype wire

//--- verification/scl_config_loader_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module scl_config_loader_asserts #(
  parameter int POR_CYC = 20
) (
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               reconfig_request_n,
  input wire scl_pkg::scl_pins_t pins,
  input wire logic               bitValid,
  input wire logic               userMode,
  input wire logic               serialPinOe,
  input wire logic               userPinOe
);
  localparam int POR_MAX = POR_CYC + 8;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  por_hold_a: assert property ($rose(rstn) |-> pins.cfgStatusOe [*8])
    else $error("status not held low after reset");
  por_release_a: assert property ($rose(rstn) |-> ##[1:POR_MAX] !pins.cfgStatusOe)
    else $error("status never released");
  load_done_low_a: assert property (pins.cfgStatusOe |-> !pins.cfgComplete)
    else $error("complete high while status low");
  user_levels_a: assert property (userMode |-> pins.cfgComplete && !pins.cfgStatusOe)
    else $error("user mode without idle levels");
  restart_exit_a: assert property (userMode && !reconfig_request_n |-> ##[1:4] !userMode)
    else $error("request low did not leave user mode");
  serial_pin_a: assert property (serialPinOe == (userMode && userPinOe))
    else $error("serial pin drive not gated by user mode");
  init_done_a: assert property (userMode |-> !pins.initDoneOe)
    else $error("init-done still pulled low in user mode");
  init_delay_a: assert property ($rose(userMode) |-> $past(pins.cfgComplete, 8))
    else $error("user mode too soon after complete");
  // Last bit and the rise of complete share one edge; complete must not precede a bit
  bit_in_load_a: assert property (bitValid |-> !$past(pins.cfgComplete) && !pins.cfgStatusOe)
    else $error("bit accepted outside loading");
  cover property ($rose(userMode));
  cover property (userMode && !reconfig_request_n);
  cover property (bitValid ##[1:40] pins.cfgComplete);
endmodule : scl_config_loader_asserts
bind scl_config_loader scl_config_loader_asserts #(.POR_CYC(POR_CYC)) u_asserts (
  .sys_clk(sys_clk), .rstn(rstn), .reconfig_request_n(reconfig_request_n), .pins(pins),
  .bitValid(bitValid), .userMode(userMode), .serialPinOe(serialPinOe), .userPinOe(userPinOe)
);
`default_nettype wire

//--- verification/scl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scl_host_model (
  input  wire logic sys_clk,
  output logic      reconfig_request_n,
  output logic      config_clock,
  output logic      config_serial_in
);
  initial begin
    reconfig_request_n = 1'b1;
    config_clock = 1'b0;
    config_serial_in = 1'b0;
  end
  task automatic restart;
    reconfig_request_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reconfig_request_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : restart
  task automatic send(input logic [15:0] d, input int hp);
    // Last data fall plus one more: exactly two falls after complete
    for (int i = 0; i < 17; i++) begin
      config_serial_in <= (i < 16) ? d[i] : ~config_serial_in;
      if (i == 16) repeat (6) @(posedge sys_clk);
      repeat (hp) @(posedge sys_clk);
      config_clock <= 1'b1;
      repeat (hp) @(posedge sys_clk);
      config_clock <= 1'b0;
    end
    // Clock then parked low, never left floating
    config_serial_in <= ~config_serial_in;
  endtask : send
endmodule : scl_host_model
`default_nettype wire

//--- verification/tb_serial_config_loader.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module tb_serial_config_loader;
  logic sys_clk = 1'b0;
  logic rstn, user_init_clock, initDoneEnable, userClockInitSel, oscTick, reconfigStrobe;
  logic watchdogRestart, watchdogEnable, userPinOut, userPinOe;
  logic reconfig_request_n, config_clock, config_serial_in;
  logic serialPinOut, serialPinOe, serialPinUserIn, bitValid, bitData, userMode, watchdogExpired;
  scl_pkg::scl_pins_t pins;
  logic [2:0] ucnt;
  logic [15:0] d;
  logic expQ[$];
  logic wdSeen = 1'b0;
  integer seed = 32'h12D3B57F;
  int bad_count = 0;
  int n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  scl_host_model host (.sys_clk, .reconfig_request_n, .config_clock, .config_serial_in);
  scl_config_loader #(.POR_CYC(20), .INIT_CYC(10), .USR_PERIODS(8), .BITS(64'h10),
    .WDOG_TICKS(16)) u_dut (.sys_clk, .rstn, .reconfig_request_n, .config_clock,
    .config_serial_in, .user_init_clock, .initDoneEnable, .userClockInitSel, .oscTick,
    .reconfigStrobe, .watchdogRestart, .watchdogEnable, .userPinOut, .userPinOe, .pins,
    .serialPinOut, .serialPinOe, .serialPinUserIn, .bitValid, .bitData, .userMode,
    .watchdogExpired);
  always @(posedge sys_clk) begin
    ucnt <= ucnt + 3'h1;
    user_init_clock <= ucnt[2];
    oscTick <= &ucnt;
    userPinOut <= $random(seed);
    userPinOe <= $random(seed);
    if (watchdogExpired === 1'b1) wdSeen <= 1'b1;
  end
  always @(posedge sys_clk) begin
    logic e;
    if (bitValid === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : ~bitData;
      `CHK("bitData", e, bitData)
    end
  end
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic wait_for(input int w);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        bad_count++;
        $display("[FAIL] wait %0d expected 1 seen 0", w);
        complete_run();
      end
    end while (!((w == 0 && pins.cfgStatusOe === 1'b0) || (w == 2 && userMode === 1'b1)
      || (w == 3 && userMode === 1'b0)));
  endtask : wait_for
  initial begin
    {rstn, initDoneEnable, userClockInitSel, reconfigStrobe} = 4'h0;
    {watchdogRestart, watchdogEnable, ucnt} = 5'h00;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_for(0);
    `CHK("completeIdle", 1'b0, pins.cfgComplete)
    for (int m = 0; m < 2; m++) begin
      userClockInitSel <= m[0];
      initDoneEnable <= ~m[0];
      d = 16'($random(seed));
      for (int i = 0; i < 16; i++) expQ.push_back(d[i]);
      host.restart();
      wait_for(0);
      host.send(d, 2 + m);
      `CHK("initLow", initDoneEnable, pins.initDoneOe)
      wait_for(2);
      `CHK("complete", 1'b1, pins.cfgComplete)
      `CHK("initDone", 1'b0, pins.initDoneOe)
      `CHK("serialOe", userPinOe, serialPinOe)
      `CHK("serialOut", userPinOut, serialPinOut)
      `CHK("serialIn", config_serial_in, serialPinUserIn)
      `CHK("bitsLeft", 0, expQ.size())
      if (m == 0) begin
        // Restart strobe late in the count keeps user mode past the first expiry
        watchdogEnable <= 1'b1;
        repeat (60) @(posedge sys_clk);
        watchdogRestart <= 1'b1;
        repeat (26) @(posedge sys_clk);
        watchdogRestart <= 1'b0;
        repeat (64) @(posedge sys_clk);
        `CHK("wdogKept", 1'b1, userMode)
        `CHK("wdogQuiet", 1'b0, wdSeen)
        wait_for(3);
        `CHK("wdogFired", 1'b1, wdSeen)
        watchdogEnable <= 1'b0;
      end
    end
    // Short strobe must be ignored, full-width one restarts
    reconfigStrobe <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reconfigStrobe <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK("shortStrobe", 1'b1, userMode)
    reconfigStrobe <= 1'b1;
    repeat (26) @(posedge sys_clk);
    reconfigStrobe <= 1'b0;
    wait_for(3);
    `CHK("strobeExit", 1'b0, userMode)
    complete_run();
  end
endmodule : tb_serial_config_loader
`default_nettype wire
